// file: core/iafc_consts.svh
`ifndef IAFC_CONSTS_SVH
`define IAFC_CONSTS_SVH
// --------------------------------------------------------------
// register offsets on the special function register port
// --------------------------------------------------------------
`define IAFC_OFF_MAIN_CTRL 4'h0
`define IAFC_OFF_RESET_KEY 4'h1
`define IAFC_OFF_TIME_CLR 4'h2
`define IAFC_OFF_ADDR_LOW 4'h3
`define IAFC_OFF_ADDR_HIGH 4'h4
`define IAFC_OFF_DATA_BASE 4'h5
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define IAFC_BIT_ENABLED 7
`define IAFC_BIT_MODE_HI 6
`define IAFC_BIT_MODE_LO 4
`define IAFC_BIT_TRIGGER 3
`define IAFC_BIT_START 2
`define IAFC_BIT_RD_EN 1
`define IAFC_BIT_RD_GO 0
`define IAFC_BIT_TIME_SEL 1
`define IAFC_BIT_BUF_CLR 0
// --------------------------------------------------------------
// values and timing
// --------------------------------------------------------------
`define IAFC_RESET_VAL 8'h00
`define IAFC_RESET_KEY 8'h55
`define IAFC_PAGE_LAST 5'h1f
`define IAFC_PAT_W1_LOW 8'h00
`define IAFC_PAT_W2_LOW 8'h0d
`define IAFC_PAT_W3_LOW 8'hc3
`define IAFC_PAT_W1_HIGH 8'h04
`define IAFC_PAT_W2_HIGH 8'h09
`define IAFC_PAT_W3_HIGH 8'h40
`define IAFC_CLK_MHZ 250
`define IAFC_T_ERASE_SHORT_US 3200
`define IAFC_T_WRITE_SHORT_US 2200
`define IAFC_T_ERASE_LONG_US 3700
`define IAFC_T_WRITE_LONG_US 3000
`define IAFC_UNLOCK_WIN_CYC 1024
`endif

// file: core/iafc_pkg.sv
package iafc_pkg;
   // --------------------------------------------------------------
   // operation mode field codes
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      IAFC_MODE_WRITE = 3'b000,
      IAFC_MODE_ERASE = 3'b001,
      IAFC_MODE_RSV2 = 3'b010,
      IAFC_MODE_READ = 3'b011,
      IAFC_MODE_RSV4 = 3'b100,
      IAFC_MODE_RSV5 = 3'b101,
      IAFC_MODE_ENABLE = 3'b110,
      IAFC_MODE_RSV7 = 3'b111
   } iafc_mode_type;
   // --------------------------------------------------------------
   // sequencer states
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      IAFC_IDLE = 2'b00,
      IAFC_BUSY = 2'b01,
      IAFC_CLEAR = 2'b10
   } iafc_state_type;
   // request to the flash array
   typedef struct packed {
      logic go;
      logic erase;
      logic [8:0] page;
      logic [31:0] mask;
   } iafc_flash_req_type;
endpackage

// file: core/iafc_ctrl.sv
`timescale 1ns/1ns
`include "iafc_consts.svh"
// Operation
// - key 55h written pulses chip reset
// - select 0: erase 3.2ms, write 2.2ms
// - select 1: erase 3.7ms, write 3.0ms
// - buffer clear bit self clears when done
// - upper six timing bits read zero
// - 14-bit address, high register bits 13:8
// - low byte write only stores register
// - first pair high byte write loads buffer when unlocked and idle, increments address
// - three more readable data word pairs
// - good unlock sets enabled status bit
// - tagging increments address, stops at page end
// - erase only tagged words
// - erase and write refused until unlocked
// - unlock: mode 110, trigger, fixed pattern
// - window timeout clears trigger, checks pattern
// - mode codes: write, erase, read, enable
// - start bit launches operation, clears when done
module iafc_ctrl #(
   parameter int CLK_MHZ = `IAFC_CLK_MHZ,
   parameter int T_ERASE_SHORT_US = `IAFC_T_ERASE_SHORT_US,
   parameter int T_WRITE_SHORT_US = `IAFC_T_WRITE_SHORT_US,
   parameter int T_ERASE_LONG_US = `IAFC_T_ERASE_LONG_US,
   parameter int T_WRITE_LONG_US = `IAFC_T_WRITE_LONG_US,
   parameter int UNLOCK_WIN_CYC = `IAFC_UNLOCK_WIN_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic chip_reset_req,
   output logic cpu_stall,
   output iafc_pkg::iafc_flash_req_type fl_req,
   input wire logic [4:0] fl_rd_idx,
   output logic [15:0] fl_rd_data
);
   // --------------------------------------------------------------
   // constants
   // --------------------------------------------------------------
   localparam int US_CYC = CLK_MHZ * 1000 / 1000; // cycles per microsecond
   localparam logic [7:0] US_LAST = 8'(US_CYC - 1);
   localparam logic [15:0] WIN_LOAD = 16'(UNLOCK_WIN_CYC - 1);
   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   logic en_r, en_nxt;
   iafc_pkg::iafc_mode_type mode_r, mode_nxt;
   logic trig_r, trig_nxt;
   logic start_r, start_nxt;
   logic rden_r, rden_nxt;
   logic rdgo_r, rdgo_nxt;
   logic [7:0] key_r, key_nxt;
   logic tsel_r, tsel_nxt;
   logic clr_r, clr_nxt;
   logic [13:0] addr_r, addr_nxt;
   logic [7:0] dlo_r [4];
   logic [7:0] dlo_nxt [4];
   logic [7:0] dhi_r [4];
   logic [7:0] dhi_nxt [4];
   iafc_pkg::iafc_state_type state_r, state_nxt;
   logic [7:0] div_r, div_nxt;
   logic [11:0] dur_r, dur_nxt;
   logic [15:0] win_r, win_nxt;
   logic [4:0] cidx_r, cidx_nxt;
   logic [31:0] mask_r, mask_nxt;
   logic rst_r, rst_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   iafc_pkg::iafc_flash_req_type req_r, req_nxt;
   logic [15:0] buf_r [32];
   logic [15:0] bufo_r;
   logic buf_we;
   logic [4:0] buf_widx;
   logic [15:0] buf_wdata;
   logic tick;
   logic pat_ok;
   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // write strobe for one register offset
   function automatic logic wr_at(input logic [3:0] off);
      return reg_wr && (reg_addr == off);
   endfunction
   // busy time in microseconds for the selected operation
   function automatic logic [11:0] op_time(input logic erase, input logic sel);
      logic [11:0] t;
      t = 12'(T_WRITE_SHORT_US);
      if (erase && !sel) begin
         t = 12'(T_ERASE_SHORT_US);
      end else if (erase && sel) begin
         t = 12'(T_ERASE_LONG_US);
      end else if (sel) begin
         t = 12'(T_WRITE_LONG_US);
      end
      return t;
   endfunction
   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   // register writes, unlock window, sequencer and buffer clear
   always_comb begin
      en_nxt = en_r;
      mode_nxt = mode_r;
      trig_nxt = trig_r;
      start_nxt = start_r;
      rden_nxt = rden_r;
      rdgo_nxt = rdgo_r;
      key_nxt = key_r;
      tsel_nxt = tsel_r;
      clr_nxt = clr_r;
      addr_nxt = addr_r;
      dlo_nxt = dlo_r;
      dhi_nxt = dhi_r;
      state_nxt = state_r;
      win_nxt = win_r;
      dur_nxt = dur_r;
      cidx_nxt = cidx_r;
      mask_nxt = mask_r;
      rdata_nxt = rdata_r;
      buf_we = 1'b0;
      buf_widx = addr_r[4:0];
      buf_wdata = {dhi_r[0], dlo_r[0]};
      tick = (div_r == US_LAST);
      div_nxt = tick ? 8'h00 : div_r + 8'h01;
      rst_nxt = 1'b0;
      req_nxt = req_r;
      req_nxt.go = 1'b0;
      pat_ok = (dlo_r[1] == `IAFC_PAT_W1_LOW) && (dhi_r[1] == `IAFC_PAT_W1_HIGH)
         && (dlo_r[2] == `IAFC_PAT_W2_LOW) && (dhi_r[2] == `IAFC_PAT_W2_HIGH)
         && (dlo_r[3] == `IAFC_PAT_W3_LOW) && (dhi_r[3] == `IAFC_PAT_W3_HIGH);
      // software writes; the processor is stalled while busy
      if (state_r != iafc_pkg::IAFC_BUSY) begin
         if (wr_at(`IAFC_OFF_RESET_KEY)) begin
            key_nxt = reg_wdata;
            rst_nxt = (reg_wdata == `IAFC_RESET_KEY);
         end
         if (wr_at(`IAFC_OFF_MAIN_CTRL)) begin
            if (!reg_wdata[`IAFC_BIT_ENABLED]) begin
               en_nxt = 1'b0; // writing one has no effect
            end
            mode_nxt = iafc_pkg::iafc_mode_type'(reg_wdata[`IAFC_BIT_MODE_HI:`IAFC_BIT_MODE_LO]);
            rden_nxt = reg_wdata[`IAFC_BIT_RD_EN];
            rdgo_nxt = reg_wdata[`IAFC_BIT_RD_GO];
            trig_nxt = reg_wdata[`IAFC_BIT_TRIGGER];
            if (reg_wdata[`IAFC_BIT_TRIGGER] && !trig_r) begin
               win_nxt = WIN_LOAD;
            end
            // start only when unlocked, idle, in write or erase mode
            if (reg_wdata[`IAFC_BIT_START] && en_r && state_r == iafc_pkg::IAFC_IDLE
                && (reg_wdata[`IAFC_BIT_MODE_HI:`IAFC_BIT_MODE_LO] == iafc_pkg::IAFC_MODE_WRITE
                || reg_wdata[`IAFC_BIT_MODE_HI:`IAFC_BIT_MODE_LO] == iafc_pkg::IAFC_MODE_ERASE)) begin
               start_nxt = 1'b1;
               state_nxt = iafc_pkg::IAFC_BUSY;
               div_nxt = 8'h00;
               dur_nxt = op_time(reg_wdata[`IAFC_BIT_MODE_LO], tsel_r);
               req_nxt.go = 1'b1;
               req_nxt.erase = reg_wdata[`IAFC_BIT_MODE_LO];
               req_nxt.page = addr_r[13:5];
               req_nxt.mask = mask_r;
            end
         end
         if (wr_at(`IAFC_OFF_TIME_CLR)) begin
            tsel_nxt = reg_wdata[`IAFC_BIT_TIME_SEL];
            if (reg_wdata[`IAFC_BIT_BUF_CLR] && state_r == iafc_pkg::IAFC_IDLE) begin
               clr_nxt = 1'b1;
               state_nxt = iafc_pkg::IAFC_CLEAR;
               cidx_nxt = 5'h00;
            end
         end
         if (wr_at(`IAFC_OFF_ADDR_LOW)) begin
            addr_nxt[7:0] = reg_wdata;
         end
         if (wr_at(`IAFC_OFF_ADDR_HIGH)) begin
            addr_nxt[13:8] = reg_wdata[5:0];
         end
         for (int i = 0; i < 4; i++) begin
            if (wr_at(4'(`IAFC_OFF_DATA_BASE + 2 * i))) begin
               dlo_nxt[i] = reg_wdata;
            end
            if (wr_at(4'(`IAFC_OFF_DATA_BASE + 2 * i + 1))) begin
               dhi_nxt[i] = reg_wdata;
            end
         end
         // first high byte loads the buffer and tags the word
         if (wr_at(4'(`IAFC_OFF_DATA_BASE + 1)) && en_r && state_r == iafc_pkg::IAFC_IDLE) begin
            buf_we = 1'b1;
            buf_wdata = {reg_wdata, dlo_r[0]};
            mask_nxt[addr_r[4:0]] = 1'b1;
            if (addr_r[4:0] != `IAFC_PAGE_LAST) begin
               addr_nxt = addr_r + 14'h0001;
            end
         end
      end
      // unlock window; grant after software clear so the set wins
      if (trig_r) begin
         if (win_r == 16'h0000) begin
            trig_nxt = 1'b0;
            if (mode_r == iafc_pkg::IAFC_MODE_ENABLE && pat_ok) begin
               en_nxt = 1'b1;
            end
         end else begin
            win_nxt = win_r - 16'h0001;
         end
      end
      // busy timing and automatic buffer clear
      unique case (state_r)
         iafc_pkg::IAFC_IDLE: begin
         end
         iafc_pkg::IAFC_BUSY: begin
            if (tick) begin
               if (dur_r <= 12'h001) begin
                  start_nxt = 1'b0;
                  state_nxt = iafc_pkg::IAFC_CLEAR;
                  cidx_nxt = 5'h00;
               end else begin
                  dur_nxt = dur_r - 12'h001;
               end
            end
         end
         iafc_pkg::IAFC_CLEAR: begin
            buf_we = 1'b1;
            buf_widx = cidx_r;
            buf_wdata = 16'h0000;
            cidx_nxt = cidx_r + 5'h01;
            if (cidx_r == `IAFC_PAGE_LAST) begin
               clr_nxt = 1'b0;
               mask_nxt = 32'h0000_0000;
               state_nxt = iafc_pkg::IAFC_IDLE;
            end
         end
         default: begin
            state_nxt = iafc_pkg::IAFC_IDLE;
         end
      endcase
      // register read port
      if (reg_rd) begin
         unique case (reg_addr)
            `IAFC_OFF_MAIN_CTRL: rdata_nxt = {en_r, mode_r, trig_r, start_r, rden_r, rdgo_r};
            `IAFC_OFF_RESET_KEY: rdata_nxt = key_r;
            `IAFC_OFF_TIME_CLR: rdata_nxt = {6'h00, tsel_r, clr_r};
            `IAFC_OFF_ADDR_LOW: rdata_nxt = addr_r[7:0];
            `IAFC_OFF_ADDR_HIGH: rdata_nxt = {2'h0, addr_r[13:8]};
            4'h5: rdata_nxt = dlo_r[0];
            4'h6: rdata_nxt = dhi_r[0];
            4'h7: rdata_nxt = dlo_r[1];
            4'h8: rdata_nxt = dhi_r[1];
            4'h9: rdata_nxt = dlo_r[2];
            4'ha: rdata_nxt = dhi_r[2];
            4'hb: rdata_nxt = dlo_r[3];
            4'hc: rdata_nxt = dhi_r[3];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   // control and data registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         en_r <= 1'b0;
         mode_r <= iafc_pkg::IAFC_MODE_WRITE;
         trig_r <= 1'b0;
         start_r <= 1'b0;
         rden_r <= 1'b0;
         rdgo_r <= 1'b0;
         key_r <= `IAFC_RESET_VAL;
         tsel_r <= 1'b0;
         clr_r <= 1'b0;
         addr_r <= 14'h0000;
         for (int i = 0; i < 4; i++) begin
            dlo_r[i] <= `IAFC_RESET_VAL;
            dhi_r[i] <= `IAFC_RESET_VAL;
         end
         state_r <= iafc_pkg::IAFC_IDLE;
         div_r <= 8'h00;
         dur_r <= 12'h000;
         win_r <= 16'h0000;
         cidx_r <= 5'h00;
         mask_r <= 32'h0000_0000;
         rst_r <= 1'b0;
         rdata_r <= 8'h00;
         req_r <= '0;
      end else begin
         en_r <= en_nxt;
         mode_r <= mode_nxt;
         trig_r <= trig_nxt;
         start_r <= start_nxt;
         rden_r <= rden_nxt;
         rdgo_r <= rdgo_nxt;
         key_r <= key_nxt;
         tsel_r <= tsel_nxt;
         clr_r <= clr_nxt;
         addr_r <= addr_nxt;
         dlo_r <= dlo_nxt;
         dhi_r <= dhi_nxt;
         state_r <= state_nxt;
         div_r <= div_nxt;
         dur_r <= dur_nxt;
         win_r <= win_nxt;
         cidx_r <= cidx_nxt;
         mask_r <= mask_nxt;
         rst_r <= rst_nxt;
         rdata_r <= rdata_nxt;
         req_r <= req_nxt;
      end
   end

   // page write buffer, no reset; cleared by the clear sequence
   always_ff @(posedge clock) begin
      if (buf_we) begin
         buf_r[buf_widx] <= buf_wdata;
      end
   end
   // buffer read port for the flash array
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bufo_r <= 16'h0000;
      end else begin
         bufo_r <= buf_r[fl_rd_idx];
      end
   end
   // outputs
   assign reg_rdata = rdata_r;
   assign chip_reset_req = rst_r;
   assign cpu_stall = (state_r == iafc_pkg::IAFC_BUSY);
   assign fl_req = req_r;
   assign fl_rd_data = bufo_r;
endmodule

// file: tb/iafc_ctrl_properties.sv
`timescale 1ns/1ns
module iafc_ctrl_checker #(
   parameter int CLK_MHZ = 4,
   parameter int T_WRITE_SHORT_US = 2,
   parameter int T_ERASE_LONG_US = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic chip_reset_req,
   input wire logic cpu_stall,
   input wire iafc_pkg::iafc_flash_req_type fl_req
);
   localparam int BMIN = CLK_MHZ * T_WRITE_SHORT_US;
   localparam int BMAX = CLK_MHZ * T_ERASE_LONG_US + 1;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // key writes and the reset pulse they cause
   property p_key; reg_wr && reg_addr == 4'h1 |=>
      chip_reset_req == ($past(reg_wdata) == 8'h55 && !$past(cpu_stall)); endproperty
   a_key: assert property (p_key) else $error("key pulse wrong");
   property p_key_src; chip_reset_req |-> $past(reg_wr && reg_addr == 4'h1); endproperty
   a_key_src: assert property (p_key_src) else $error("stray reset pulse");
   // start pulse and busy span
   property p_go; fl_req.go |-> cpu_stall; endproperty
   a_go: assert property (p_go) else $error("go without stall");
   property p_go_pulse; $rose(cpu_stall) |-> fl_req.go ##1 !fl_req.go; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("go not one pulse");
   property p_busy_min; $rose(cpu_stall) |-> cpu_stall[*8]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_max; $rose(cpu_stall) |-> ##[BMIN:BMAX] !cpu_stall; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   property p_page; !fl_req.go |-> $stable(fl_req.page) && $stable(fl_req.erase); endproperty
   a_page: assert property (p_page) else $error("request moved");
   // unimplemented read bits
   property p_tc; reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:2] == 6'h00; endproperty
   a_tc: assert property (p_tc) else $error("timing bits not zero");
   property p_ah; reg_rd && reg_addr == 4'h4 |=> reg_rdata[7:6] == 2'h0; endproperty
   a_ah: assert property (p_ah) else $error("address high bits not zero");
endmodule
bind iafc_ctrl iafc_ctrl_checker #(.CLK_MHZ(CLK_MHZ), .T_WRITE_SHORT_US(T_WRITE_SHORT_US),
   .T_ERASE_LONG_US(T_ERASE_LONG_US)) chk (.*);

// file: tb/iafc_flash_model.sv
`timescale 1ns/1ns
module iafc_flash_model (
   input wire logic clock,
   input wire iafc_pkg::iafc_flash_req_type fl_req,
   input wire logic [15:0] fl_rd_data,
   output logic [4:0] fl_rd_idx
);
   logic [15:0] mem [int];
   iafc_pkg::iafc_flash_req_type op_r;
   logic [5:0] cnt_r = 6'h00;
   logic act_r = 1'b0;
   logic [4:0] prev_r = 5'h00;
   int k;
   // walk the buffer for 32 cycles after go; idle index changes every cycle
   assign fl_rd_idx = act_r ? cnt_r[4:0] : ~prev_r;
   // latch the request, then program or erase the tagged words
   always @(posedge clock) begin
      prev_r <= fl_rd_idx;
      cnt_r <= cnt_r + 6'h01;
      if (fl_req.go === 1'b1) begin
         op_r <= fl_req;
         act_r <= 1'b1;
         cnt_r <= 6'h00;
      end else if (cnt_r == 6'h20) begin
         act_r <= 1'b0;
      end
      if (act_r && cnt_r != 6'h00 && op_r.mask[prev_r]) begin
         k = {op_r.page, prev_r};
         mem[k] = op_r.erase ? 16'h0000 : fl_rd_data;
      end
   end
endmodule

// file: tb/iap_flash_erase_write_ctrl_test.sv
`timescale 1ns/1ns
module iap_flash_erase_write_ctrl_test;
   localparam int M = 4;
   localparam int WIN = 16;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic chip_reset_req;
   logic cpu_stall;
   iafc_pkg::iafc_flash_req_type fl_req;
   logic [4:0] fl_rd_idx;
   logic [15:0] fl_rd_data;
   int fail_count = 0;
   int n_checks = 0;
   int seed = 20;
   int n_rst = 0;
   int ref_mem[int];
   int i, j, cyc, pg;
   logic [15:0] w [3];
   iafc_ctrl #(.CLK_MHZ(M), .T_ERASE_SHORT_US(3), .T_WRITE_SHORT_US(2), .T_ERASE_LONG_US(4),
      .T_WRITE_LONG_US(3), .UNLOCK_WIN_CYC(WIN)) uut (.clock(clock), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .chip_reset_req(chip_reset_req), .cpu_stall(cpu_stall),
      .fl_req(fl_req), .fl_rd_idx(fl_rd_idx), .fl_rd_data(fl_rd_data));
   iafc_flash_model fl (.clock(clock), .fl_req(fl_req), .fl_rd_data(fl_rd_data),
      .fl_rd_idx(fl_rd_idx));
   // clock, reset pulse counter and watchdog
   initial forever #2 clock = ~clock;
   always @(posedge clock) if (chip_reset_req === 1'b1) n_rst++;
   initial begin
      #200000;
      fail_count++;
      finish_test;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clock);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge clock);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      chk(32'(reg_rdata), 32'(e));
   endtask
   task automatic unlock(logic [7:0] last);
      wr(4'h0, 8'h68);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h04);
      wr(4'h9, 8'h0d);
      wr(4'ha, 8'h09);
      wr(4'hb, 8'hc3);
      wr(4'hc, last);
      repeat (WIN) @(posedge clock);
   endtask
   task automatic run_op(logic [7:0] c, int e);
      wr(4'h0, c);
      cyc = 0;
      while (cpu_stall === 1'b1 && cyc < 100) begin
         @(posedge clock);
         #1;
         cyc++;
      end
      chk(32'(cyc), 32'(e));
      // let the array model and the automatic buffer clear finish
      repeat (32) @(posedge clock);
      #1;
   endtask
   task automatic cmp_page(int p);
      int k;
      for (int q = 0; q < 32; q++) begin
         k = p * 32 + q;
         chk(fl.mem.exists(k) ? 32'(fl.mem[k]) : 32'hdead,
            ref_mem.exists(k) ? 32'(ref_mem[k]) : 32'hdead);
      end
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      #1;
      nrst = 1'b1;
      for (i = 0; i < 16; i++) rd(4'(i), 8'h00);
      for (i = 7; i < 13; i++) begin
         j = $random(seed);
         wr(4'(i), 8'(j));
         rd(4'(i), 8'(j));
      end
      wr(4'h4, 8'hff);
      rd(4'h4, 8'h3f);
      wr(4'h2, 8'hfe);
      rd(4'h2, 8'h02);
      wr(4'h1, 8'h54);
      rd(4'h1, 8'h54);
      wr(4'h1, 8'h55);
      @(posedge clock);
      #1;
      chk(32'(n_rst), 32'd1);
      wr(4'h3, 8'h10);
      wr(4'h5, 8'h12);
      wr(4'h6, 8'h34);
      rd(4'h3, 8'h10);
      run_op(8'h84, 0);
      rd(4'h0, 8'h00);
      unlock(8'h41);
      rd(4'h0, 8'h60);
      unlock(8'h40);
      rd(4'h0, 8'he0);
      // read mode is not an erase or write: start stays refused
      run_op(8'hb4, 0);
      rd(4'h0, 8'hb0);
      for (i = 0; i < 2; i++) begin
         pg = {$random(seed)} % 512;
         wr(4'h2, 8'(2 * i + 1));
         rd(4'h2, 8'(2 * i + 1));
         repeat (32) @(posedge clock);
         rd(4'h2, 8'(2 * i));
         wr(4'h3, 8'((pg % 8) * 32 + 28));
         wr(4'h4, 8'(pg / 8));
         for (j = 0; j < 6; j++) wr(4'h6, 8'h00);
         rd(4'h3, 8'((pg % 8) * 32 + 31));
         for (j = 28; j < 32; j++) ref_mem[pg * 32 + j] = 0;
         run_op(8'h94, M * (i ? 4 : 3));
         rd(4'h0, 8'h90);
         cmp_page(pg);
         wr(4'h3, 8'((pg % 8) * 32 + 30));
         for (j = 0; j < 3; j++) begin
            w[j] = 16'($random(seed));
            wr(4'h5, w[j][7:0]);
            wr(4'h6, w[j][15:8]);
         end
         wr(4'h5, ~w[2][7:0]);
         ref_mem[pg * 32 + 30] = w[0];
         ref_mem[pg * 32 + 31] = w[2];
         // key write lands while the processor is stalled
         fork
            run_op(8'h84, M * (i ? 3 : 2));
            begin
               repeat (3) @(posedge clock);
               wr(4'h1, 8'h55);
            end
         join
         chk(32'(n_rst), 32'd1);
         cmp_page(pg);
      end
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      run_op(8'h04, 0);
      nrst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      nrst = 1'b1;
      rd(4'h2, 8'h00);
      finish_test;
   end
endmodule
